// [core/rtcc_consts.svh]
/*
 * Constants of the real-time clock control block: location indices,
 * bit positions, power-on values and timing counts.
 * Assumes inclusion by bare name from the core/ directory.
 */
`ifndef RTCC_CONSTS_SVH
`define RTCC_CONSTS_SVH
// Location indices on the host I/O bus.
`define RTCC_IDX_SEC 7'h00
`define RTCC_IDX_MIN 7'h02
`define RTCC_IDX_HOUR 7'h04
`define RTCC_IDX_YEAR 7'h09
`define RTCC_IDX_RATE 7'h0a
`define RTCC_IDX_CTRL 7'h0b
`define RTCC_IDX_FLAGS 7'h0c
`define RTCC_IDX_ID 7'h0d
`define RTCC_IDX_RAM0 7'h0e
// Control register bit positions.
`define RTCC_CTRL_DSE 0
`define RTCC_CTRL_H24 1
`define RTCC_CTRL_BIN 2
`define RTCC_CTRL_UIE 4
`define RTCC_CTRL_AIE 5
`define RTCC_CTRL_PIE 6
`define RTCC_CTRL_SET 7
// Rate register fields.
`define RTCC_OSC_LSB 4
`define RTCC_OSC_RUN 3'h2
// Power-loss initial values.
`define RTCC_RATE_INIT 7'h26
`define RTCC_CTRL_INIT 8'h02
// Alarm bytes with both top bits set match any value.
`define RTCC_DONT_CARE 2'h3
// Timing: system clock, time base and update-in-progress lead.
`define RTCC_CLK_HZ 100000000
`define RTCC_TICK_HZ 32768
`define RTCC_CHAIN_W 15
`define RTCC_UIP_LEAD_US 244
`define RTCC_UIP_LEAD_TICKS \
    ((`RTCC_UIP_LEAD_US * `RTCC_TICK_HZ + 999999) / 1000000)
`endif

// [core/rtcc_pkg.sv]
/*
 * Types shared by the real-time clock control block.
 * Assumes nothing of its surroundings.
 */
package rtcc_pkg;
    // Update sequencer states, one-hot.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_UPD = 3'b010,
        ST_CHK = 3'b100
    } rtcc_state_type;
    // Time and calendar bytes in stored format.
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] mon;
        logic [7:0] date;
        logic [7:0] dow;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } rtcc_time_type;
endpackage

// [core/rtcc_div_if.sv]
/*
 * Time-base signals between the divider chain and the control logic.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface rtcc_div_if;
    logic run;
    logic tick;
    logic [14:0] chain;
    logic sec;
    logic pre;
    modport src (input run, output tick, output chain, output sec,
        output pre);
    modport snk (output run, input tick, input chain, input sec,
        input pre);
endinterface
`default_nettype wire

// [core/rtcc_divider.sv]
/*
 * Divider chain: makes a 32.768 kHz tick enable from the system clock,
 * counts ticks, and flags the second boundary and the update lead.
 * Assumes run is a level from the same clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rtcc_consts.svh"
module rtcc_divider #(
    parameter int CLK_PER_TICK = `RTCC_CLK_HZ / `RTCC_TICK_HZ,
    parameter int LEAD_TICKS = `RTCC_UIP_LEAD_TICKS
) (
    input wire logic clk_i,
    rtcc_div_if.src bus
);
    localparam int CW = (CLK_PER_TICK > 1) ? $clog2(CLK_PER_TICK) : 1;
    localparam logic [14:0] PRE_AT = 15'((1 << 15) - LEAD_TICKS - 1);
    logic [CW-1:0] cnt;

    // Tick enable; a stopped oscillator holds the whole chain at zero.
    always_ff @(posedge clk_i) begin
        if (!bus.run) begin
            cnt <= '0;
            bus.tick <= 1'b0;
        end else if (cnt == CW'(CLK_PER_TICK - 1)) begin
            cnt <= '0;
            bus.tick <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
            bus.tick <= 1'b0;
        end
    end

    // Chain of tick counts with second and lead pulses.
    always_ff @(posedge clk_i) begin
        if (!bus.run) begin
            bus.chain <= '0;
            bus.sec <= 1'b0;
            bus.pre <= 1'b0;
        end else begin
            if (bus.tick) begin
                bus.chain <= bus.chain + 1'b1;
            end
            bus.sec <= bus.tick && (bus.chain == 15'h7fff);
            bus.pre <= bus.tick && (bus.chain == PRE_AT);
        end
    end
endmodule
`default_nettype wire

// [core/rtcc_timestep.sv]
/*
 * Next-second calculator: advances time and calendar by one second in
 * binary or BCD, 12 or 24 hour form, with daylight-saving steps.
 * Assumes the current bytes hold legal values for the chosen format.
 */
`timescale 1ns/10ps
`default_nettype none
module rtcc_timestep import rtcc_pkg::*; (
    input wire rtcc_time_type cur_i,
    input wire logic hour24_i,
    input wire logic binary_i,
    input wire logic dse_i,
    input wire logic fall_done_i,
    output var rtcc_time_type next_o,
    output logic fall_hit_o
);
    function automatic logic [7:0] to_bin(input logic [7:0] v,
        input logic bin);
        return bin ? v : 8'(v[7:4]) * 8'd10 + 8'(v[3:0]);
    endfunction

    function automatic logic [7:0] to_fmt(input logic [7:0] v,
        input logic bin);
        return bin ? v : {4'(v / 8'd10), 4'(v % 8'd10)};
    endfunction

    // One-second advance worked in binary, then put back in format.
    always_comb begin
        logic [7:0] s, m, h, d, mo, y, w, dim, hb, hf;
        s = to_bin(cur_i.sec, binary_i) + 8'd1;
        m = to_bin(cur_i.min, binary_i);
        d = to_bin(cur_i.date, binary_i);
        mo = to_bin(cur_i.mon, binary_i);
        y = to_bin(cur_i.year, binary_i);
        w = to_bin(cur_i.dow, binary_i);
        hb = to_bin({1'b0, cur_i.hour[6:0]}, binary_i);
        h = hour24_i ? to_bin(cur_i.hour, binary_i) :
            (hb == 8'd12 ? 8'd0 : hb) + (cur_i.hour[7] ? 8'd12 : 8'd0);
        hf = 8'd0;
        dim = 8'd31;
        fall_hit_o = 1'b0;
        if (dse_i && w == 8'd1 && h == 8'd1 && m == 8'd59 &&
            s == 8'd60) begin
            if (mo == 8'd4 && d <= 8'd7) begin
                h = 8'd2; // Rolls on to 3:00:00.
            end else if (mo == 8'd10 && d >= 8'd25 && !fall_done_i) begin
                h = 8'd0; // Rolls on to 1:00:00, once.
                fall_hit_o = 1'b1;
            end
        end
        if (s == 8'd60) begin
            s = 8'd0;
            m = m + 8'd1;
        end
        if (m == 8'd60) begin
            m = 8'd0;
            h = h + 8'd1;
        end
        if (h == 8'd24) begin
            h = 8'd0;
            w = (w == 8'd7) ? 8'd1 : w + 8'd1;
            d = d + 8'd1;
        end
        case (mo)
            8'd2: dim = (y[1:0] == 2'd0) ? 8'd29 : 8'd28;
            8'd4, 8'd6, 8'd9, 8'd11: dim = 8'd30;
            default: dim = 8'd31;
        endcase
        if (d > dim) begin
            d = 8'd1;
            mo = mo + 8'd1;
        end
        if (mo > 8'd12) begin
            mo = 8'd1;
            y = (y == 8'd99) ? 8'd0 : y + 8'd1;
        end
        // Hours go back as 24-hour or as 1-12 with the PM bit on top.
        if (hour24_i) begin
            next_o.hour = to_fmt(h, binary_i);
        end else begin
            hb = (h >= 8'd12) ? h - 8'd12 : h;
            hf = to_fmt((hb == 8'd0) ? 8'd12 : hb, binary_i);
            next_o.hour = {(h >= 8'd12), hf[6:0]};
        end
        next_o.sec = to_fmt(s, binary_i);
        next_o.min = to_fmt(m, binary_i);
        next_o.date = to_fmt(d, binary_i);
        next_o.mon = to_fmt(mo, binary_i);
        next_o.year = to_fmt(y, binary_i);
        next_o.dow = to_fmt(w, binary_i);
    end
endmodule
`default_nettype wire

// [core/rtcc_top.sv]
/*
 * Real-time clock control, status and interrupt block with its time,
 * calendar, alarm and battery-backed byte store.
 * Assumes a host I/O bus synchronous to clk_i and a power-loss pin.
 */
// What this block does
// - With daylight saving on, first April Sunday jumps 1:59:59 to 3:00:00.
// - With daylight saving on, last October Sunday steps 1:59:59 to 1:00:00.
// - Hour-format bit 1 keeps 24-hour time, 0 keeps 12-hour AM/PM.
// - Data-format bit 1 stores binary, 0 stores BCD.
// - Update-inhibit bit set blocks every update cycle.
// - Update-ended flag clears during an update and sets after it.
// - Alarm flag sets on a time match, don't-care bytes always match.
// - Alarm flag clears on a flags read or on reset.
// - Periodic flag sets on the chosen tap change, whatever the enable.
// - Periodic flag clears on a flags read or on reset.
// - Periodic enable gates the interrupt, never the flag.
// - Request flag is the OR of each flag ANDed with its enable.
// - Flags register: bits 4-7 update, alarm, periodic, request; reset 0.
// - ID register: revision code in bits 0-3, untouched by reset.
// - ID bit 7 reads 0 after a power loss.
// - Reset leaves time, calendar and byte store unchanged.
// - Control bits: 0 DST, 1 hours, 2 data, 4-6 enables, 7 inhibit.
// - Interrupt enables reset to 0, other control bits keep value.
// - Writing 1 to the inhibit bit also clears update-in-progress.
// - Seven time and calendar bytes update each second, alarm checked each update.
`timescale 1ns/10ps
`default_nettype none
`include "rtcc_consts.svh"
module rtcc_top import rtcc_pkg::*; #(
    parameter int NUM_LOC = 128,
    parameter int CLK_PER_TICK = `RTCC_CLK_HZ / `RTCC_TICK_HZ,
    // Revision code value is arbitrary.
    parameter logic [3:0] REV_CODE = 4'h5
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [6:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    input wire logic supply_lost_i,
    output logic clock_host_interrupt_o
);
    logic lost_meta, lost_sync;
    logic [7:0] mem [0:NUM_LOC-1];
    logic [7:0] next_time [0:9];
    logic [3:0] rate_select_field;
    logic [2:0] osc_ctrl;
    logic update_in_progress;
    logic daylight_saving_enable, hour_24, data_format_binary, set_mode;
    logic update_irq_enable, alarm_irq_enable, periodic_irq_enable;
    logic update_ended_flag, alarm_flag, periodic_flag, irq_request_flag;
    logic ram_time_valid, fall_done, fall_hit;
    logic tap_now, tap_prev, per_evt, alarm_match, rd_c;
    rtcc_state_type state;
    rtcc_time_type cur, nxt;
    rtcc_div_if div_bus ();
    localparam logic [7:0] CTRL_INIT = `RTCC_CTRL_INIT;

    // Power-loss pin passes two flops before any logic reads it.
    always_ff @(posedge clk_i) begin
        lost_meta <= supply_lost_i;
        lost_sync <= lost_meta;
    end

    assign div_bus.run = (osc_ctrl == `RTCC_OSC_RUN);
    assign rd_c = io_rd_i && (io_addr_i == `RTCC_IDX_FLAGS);

    rtcc_divider #(
        .CLK_PER_TICK(CLK_PER_TICK),
        .LEAD_TICKS(`RTCC_UIP_LEAD_TICKS)
    ) u_div (
        .clk_i(clk_i),
        .bus(div_bus)
    );

    // Current time as a struct and the next-second values per location.
    assign cur = '{year: mem[9], mon: mem[8], date: mem[7], dow: mem[6],
        hour: mem[4], min: mem[2], sec: mem[0]};
    assign next_time = '{nxt.sec, mem[1], nxt.min, mem[3], nxt.hour,
        mem[5], nxt.dow, nxt.date, nxt.mon, nxt.year};

    rtcc_timestep u_step (
        .cur_i(cur),
        .hour24_i(hour_24),
        .binary_i(data_format_binary),
        .dse_i(daylight_saving_enable),
        .fall_done_i(fall_done),
        .next_o(nxt),
        .fall_hit_o(fall_hit)
    );

    // Byte store; reset never touches it, only a power loss does.
    for (genvar i = 0; i < NUM_LOC; i++) begin : g_loc
        if (i < 10) begin : g_time
            always_ff @(posedge clk_i) begin
                if (lost_sync) begin
                    mem[i] <= (i >= 6 && i <= 8) ? 8'h01 : 8'h00;
                end else if (state == ST_UPD) begin
                    mem[i] <= next_time[i];
                end else if (io_wr_i && io_addr_i == 7'(i)) begin
                    mem[i] <= io_wdata_i;
                end
            end
        end else begin : g_ram
            always_ff @(posedge clk_i) begin
                if (lost_sync) begin
                    mem[i] <= 8'h00;
                end else if (i >= 14 && io_wr_i && io_addr_i == 7'(i)) begin
                    mem[i] <= io_wdata_i;
                end
            end
        end
    end

    // Update sequencer: a second boundary starts one update cycle.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (div_bus.sec && !set_mode) begin
                        state <= ST_UPD;
                    end
                end
                ST_UPD: state <= ST_CHK;
                ST_CHK: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Update-in-progress rises ahead of the update and ends with it.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            update_in_progress <= 1'b0;
        end else if (io_wr_i && io_addr_i == `RTCC_IDX_CTRL &&
            io_wdata_i[`RTCC_CTRL_SET]) begin
            update_in_progress <= 1'b0;
        end else if (div_bus.pre && !set_mode) begin
            update_in_progress <= 1'b1;
        end else if (state == ST_CHK) begin
            update_in_progress <= 1'b0;
        end
    end

    // Rate select and oscillator control keep their value through reset.
    always_ff @(posedge clk_i) begin
        if (lost_sync) begin
            {osc_ctrl, rate_select_field} <= `RTCC_RATE_INIT;
        end else if (io_wr_i && io_addr_i == `RTCC_IDX_RATE) begin
            {osc_ctrl, rate_select_field} <= io_wdata_i[6:0];
        end
    end

    // Control bits that reset leaves alone.
    always_ff @(posedge clk_i) begin
        if (lost_sync) begin
            {set_mode, data_format_binary, hour_24, daylight_saving_enable}
                <= {CTRL_INIT[7], CTRL_INIT[2:0]};
        end else if (io_wr_i && io_addr_i == `RTCC_IDX_CTRL) begin
            set_mode <= io_wdata_i[`RTCC_CTRL_SET];
            data_format_binary <= io_wdata_i[`RTCC_CTRL_BIN];
            hour_24 <= io_wdata_i[`RTCC_CTRL_H24];
            daylight_saving_enable <= io_wdata_i[`RTCC_CTRL_DSE];
        end
    end

    // Interrupt enables clear on reset.
    always_ff @(posedge clk_i) begin
        if (!rstn_i || lost_sync) begin
            update_irq_enable <= 1'b0;
            alarm_irq_enable <= 1'b0;
            periodic_irq_enable <= 1'b0;
        end else if (io_wr_i && io_addr_i == `RTCC_IDX_CTRL) begin
            update_irq_enable <= io_wdata_i[`RTCC_CTRL_UIE];
            alarm_irq_enable <= io_wdata_i[`RTCC_CTRL_AIE];
            periodic_irq_enable <= io_wdata_i[`RTCC_CTRL_PIE];
        end
    end

    // Periodic tap picked from the chain; rates 1 and 2 repeat 8 and 9.
    always_comb begin
        case (rate_select_field)
            4'h0: tap_now = 1'b0;
            4'h1: tap_now = div_bus.chain[6];
            4'h2: tap_now = div_bus.chain[7];
            default: tap_now = div_bus.chain[rate_select_field - 4'h2];
        endcase
    end

    always_ff @(posedge clk_i) begin
        tap_prev <= tap_now;
    end

    assign per_evt = tap_now && !tap_prev;

    // Alarm bytes match their time byte or hold a don't-care value.
    assign alarm_match =
        (mem[1][7:6] == `RTCC_DONT_CARE || mem[1] == mem[0]) &&
        (mem[3][7:6] == `RTCC_DONT_CARE || mem[3] == mem[2]) &&
        (mem[5][7:6] == `RTCC_DONT_CARE || mem[5] == mem[4]);

    // Flags: a setting event wins over a clearing read in the same cycle.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            update_ended_flag <= 1'b0;
            alarm_flag <= 1'b0;
            periodic_flag <= 1'b0;
        end else begin
            if (state == ST_CHK) begin
                update_ended_flag <= 1'b1;
            end else if (state == ST_UPD || rd_c) begin
                update_ended_flag <= 1'b0;
            end
            if (state == ST_CHK && alarm_match) begin
                alarm_flag <= 1'b1;
            end else if (rd_c) begin
                alarm_flag <= 1'b0;
            end
            if (per_evt) begin
                periodic_flag <= 1'b1;
            end else if (rd_c) begin
                periodic_flag <= 1'b0;
            end
        end
    end

    assign irq_request_flag = (periodic_flag && periodic_irq_enable) ||
        (alarm_flag && alarm_irq_enable) ||
        (update_ended_flag && update_irq_enable);

    // Interrupt output follows the request flag one cycle later.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            clock_host_interrupt_o <= 1'b0;
        end else begin
            clock_host_interrupt_o <= irq_request_flag;
        end
    end

    // Valid bit drops on power loss and returns on an ID read.
    always_ff @(posedge clk_i) begin
        if (lost_sync) begin
            ram_time_valid <= 1'b0;
        end else if (io_rd_i && io_addr_i == `RTCC_IDX_ID) begin
            ram_time_valid <= 1'b1;
        end
    end

    // Fall-back happens once per day; the day change rearms it.
    always_ff @(posedge clk_i) begin
        if (lost_sync) begin
            fall_done <= 1'b0;
        end else if (state == ST_UPD) begin
            if (fall_hit) begin
                fall_done <= 1'b1;
            end else if (nxt.date != cur.date) begin
                fall_done <= 1'b0;
            end
        end
    end

    // Read data is captured on the read strobe.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            io_rdata_o <= 8'h00;
        end else if (io_rd_i) begin
            case (io_addr_i)
                `RTCC_IDX_RATE: io_rdata_o <=
                    {update_in_progress, osc_ctrl, rate_select_field};
                `RTCC_IDX_CTRL: io_rdata_o <= {set_mode,
                    periodic_irq_enable, alarm_irq_enable, update_irq_enable,
                    1'b0, data_format_binary, hour_24,
                    daylight_saving_enable};
                `RTCC_IDX_FLAGS: io_rdata_o <= {irq_request_flag,
                    periodic_flag, alarm_flag, update_ended_flag,
                    4'h0};
                `RTCC_IDX_ID: io_rdata_o <=
                    {ram_time_valid, 3'h0, REV_CODE};
                default: io_rdata_o <= mem[io_addr_i];
            endcase
        end
    end

    // Checks on the behaviour above.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    AST_UF_CLEARED_DURING: assert property (
        state == ST_UPD |=> !update_ended_flag && state == ST_CHK)
        else $error("update flag not cleared during update");
    AST_UF_SET_AFTER: assert property (
        state == ST_UPD |=> ##1 update_ended_flag && state == ST_IDLE)
        else $error("update flag not set after update");
    AST_INHIBIT_HOLDS: assert property (
        (set_mode && state == ST_IDLE) |=> state == ST_IDLE)
        else $error("update ran while inhibited");
    AST_ALARM_SET: assert property (
        (state == ST_CHK && alarm_match) |=> alarm_flag)
        else $error("alarm flag missed a match");
    AST_ALARM_READ_CLR: assert property (
        (rd_c && !(state == ST_CHK && alarm_match)) |=> !alarm_flag)
        else $error("alarm flag survived flags read");
    AST_PF_SET: assert property (
        per_evt |=> periodic_flag)
        else $error("periodic flag missed a tap change");
    AST_PF_READ_CLR: assert property (
        (rd_c && !per_evt) |=> !periodic_flag)
        else $error("periodic flag survived flags read");
    AST_PIE_GATES: assert property (
        (periodic_flag && !periodic_irq_enable &&
        !(alarm_flag && alarm_irq_enable) &&
        !(update_ended_flag && update_irq_enable))
        |=> !clock_host_interrupt_o)
        else $error("periodic interrupt not gated by enable");
    AST_IRQ_FOLLOWS: assert property (
        irq_request_flag |=> clock_host_interrupt_o ##0
        $past(periodic_flag || alarm_flag || update_ended_flag))
        else $error("interrupt output missed request flag");
    AST_SET_CLEARS_UIP: assert property (
        (io_wr_i && io_addr_i == `RTCC_IDX_CTRL &&
        io_wdata_i[`RTCC_CTRL_SET]) |=> !update_in_progress [*2])
        else $error("inhibit write did not clear update in progress");

    COV_UPDATE_ALARM: cover property (state == ST_CHK && alarm_match);
    COV_PERIODIC_IRQ: cover property (per_evt && periodic_irq_enable);
    COV_FALL_BACK: cover property (state == ST_UPD && fall_hit);
    COV_READ_PENDING: cover property (rd_c && irq_request_flag);
endmodule
`default_nettype wire

// [sim/rtcc_host.sv]
/*
 * Host model for the clock block: byte reads and writes on the I/O bus.
 * Assumes the bus is synchronous to clk_i and is sampled on its rising edge.
 */
`timescale 1ns/10ps
`default_nettype none
module rtcc_host (
    input wire logic clk_i,
    input wire logic [7:0] io_rdata_i,
    output logic [6:0] io_addr_o,
    output logic io_wr_o,
    output logic io_rd_o,
    output logic [7:0] io_wdata_o
);
    // The bus is idle with both strobes low from time zero.
    initial begin
        io_addr_o = 7'h00;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_wdata_o = 8'h00;
    end

    // One-cycle write pulse; the data lines stop showing the byte after it.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk_i);
        io_addr_o = a;
        io_wdata_o = d;
        io_wr_o = 1'b1;
        @(negedge clk_i);
        io_wr_o = 1'b0;
        io_wdata_o = ~d;
    endtask

    // One-cycle read pulse; the byte is settled by the next falling edge.
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge clk_i);
        io_addr_o = a;
        io_rd_o = 1'b1;
        @(negedge clk_i);
        io_rd_o = 1'b0;
        d = io_rdata_i;
    endtask
endmodule
`default_nettype wire

// [sim/rtc_control_status_irq_tb.sv]
/*
 * Self-checking bench for the clock control, status and interrupt block.
 * Assumes a one-cycle tick so that one second lasts 32768 clock cycles.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module rtc_control_status_irq_tb;
    logic clk_i, rstn_i, supply_lost_i, irq, io_wr, io_rd;
    logic [6:0] io_addr;
    logic [7:0] io_wdata, io_rdata, v;
    int num_errors = 0;
    int n_tests = 0;

    rtcc_top #(.CLK_PER_TICK(1)) i_dut (.clk_i(clk_i), .rstn_i(rstn_i),
        .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd),
        .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
        .supply_lost_i(supply_lost_i), .clock_host_interrupt_o(irq));
    rtcc_host i_host (.clk_i(clk_i), .io_rdata_i(io_rdata),
        .io_addr_o(io_addr), .io_wr_o(io_wr), .io_rd_o(io_rd),
        .io_wdata_o(io_wdata));

    // Clock of 10 ns period.
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Reads one location and compares its masked value with the expectation.
    task automatic chk_rd(input logic [6:0] a, input logic [7:0] m,
        input logic [7:0] e);
        i_host.rd(a, v);
        `CHK(v & m, e)
    endtask

    task automatic wait_irq(input int lim);
        for (int i = 0; i < lim && irq !== 1'b1; i++)
            @(negedge clk_i);
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (100000) @(posedge clk_i);
        num_errors++;
        report_and_stop();
    end

    // Main sequence of tests.
    initial begin
        rstn_i = 1'b0;
        supply_lost_i = 1'b1;
        repeat (3) @(negedge clk_i);
        supply_lost_i = 1'b0;
        rstn_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk_rd(7'h0d, 8'hff, 8'h05);
        chk_rd(7'h0d, 8'hff, 8'h85);
        chk_rd(7'h0b, 8'hff, 8'h02);
        chk_rd(7'h0a, 8'h7f, 8'h26);
        i_host.wr(7'h0b, 8'h7f);
        chk_rd(7'h0b, 8'hff, 8'h77);
        $display("test power_up_and_control done");
        // Periodic flag sets with the enable off and gates only the output.
        i_host.wr(7'h0b, 8'h02);
        i_host.wr(7'h0a, 8'h23);
        repeat (20) @(negedge clk_i);
        `CHK(irq, 1'b0)
        chk_rd(7'h0c, 8'hc0, 8'h40);
        i_host.wr(7'h0b, 8'h42);
        repeat (8) @(negedge clk_i);
        `CHK(irq, 1'b1)
        i_host.wr(7'h0a, 8'h20);
        i_host.rd(7'h0c, v);
        repeat (3) @(negedge clk_i);
        chk_rd(7'h0c, 8'hc0, 8'h00);
        `CHK(irq, 1'b0)
        $display("test periodic done");
        // Binary 12-hour time one second before midnight, alarm any time.
        i_host.wr(7'h0b, 8'hb4);
        i_host.wr(7'h00, 8'h3b);
        i_host.wr(7'h02, 8'h3b);
        i_host.wr(7'h04, 8'h8b);
        i_host.wr(7'h01, 8'hc0);
        i_host.wr(7'h03, 8'hc0);
        i_host.wr(7'h05, 8'hc0);
        i_host.rd(7'h0c, v);
        i_host.wr(7'h0b, 8'h34);
        wait_irq(40000);
        `CHK(irq, 1'b1)
        chk_rd(7'h0c, 8'hff, 8'hb0);
        repeat (2) @(negedge clk_i);
        `CHK(irq, 1'b0)
        chk_rd(7'h00, 8'hff, 8'h00);
        chk_rd(7'h02, 8'hff, 8'h00);
        chk_rd(7'h04, 8'hff, 8'h0c);
        $display("test update_and_alarm done");
        // Inhibit holds the seconds byte through a whole second.
        i_host.wr(7'h0b, 8'hb4);
        chk_rd(7'h0a, 8'h80, 8'h00);
        i_host.wr(7'h00, 8'h10);
        repeat (33000) @(negedge clk_i);
        chk_rd(7'h00, 8'hff, 8'h10);
        chk_rd(7'h0c, 8'h70, 8'h00);
        $display("test inhibit done");
        // Reset in mid-run keeps time, format and validity.
        @(negedge clk_i);
        rstn_i = 1'b0;
        repeat (3) @(negedge clk_i);
        rstn_i = 1'b1;
        chk_rd(7'h0b, 8'hff, 8'h84);
        chk_rd(7'h00, 8'hff, 8'h10);
        chk_rd(7'h0c, 8'hff, 8'h00);
        chk_rd(7'h0d, 8'hff, 8'h85);
        $display("test mid_run_reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
